// file: pkg/geb_pkg.sv
// Constants and carrier types for the gesture event register bank
// How it works
// RULE1: First event byte bit 5 reports a swipe toward negative Y.
// RULE2: First event byte bit 4 reports a swipe toward positive Y.
// RULE3: First event byte bit 3 reports a swipe toward positive X.
// RULE4: First event byte bit 2 reports a swipe toward negative X.
// RULE5: First event byte bit 1 reports a press-and-hold gesture.
// RULE6: First event byte bit 0 reports a single tap.
// RULE7: Second event byte bit 2 reports a zoom gesture.
// RULE8: Second event byte bit 1 reports a scroll gesture.
// RULE9: Second event byte bit 0 reports a two-finger tap.
// RULE10: Thirty-byte snap enable array, one bit per channel, one enables snap.
// RULE11: Each row is two bytes, high first; bits 9..0 are columns 9..0.
// RULE12: Unused event byte bits always read zero.
package geb_pkg;

   localparam int unsigned ADDR_W          = 16;
   localparam int unsigned DATA_W          = 8;

   // Scalar configuration bytes, multi-byte values high byte first
   localparam int unsigned CFG_BYTES       = 24;
   localparam logic [15:0] CFG_ADDR [CFG_BYTES] = '{
      16'h0670, 16'h0671, 16'h0672, 16'h0675, 16'h0676, 16'h0677, 16'h0678, 16'h0679,
      16'h067a, 16'h06b7, 16'h06b8, 16'h06bb, 16'h06bc, 16'h06bd, 16'h06be, 16'h06bf,
      16'h06c0, 16'h06c1, 16'h06c2, 16'h06c5, 16'h06c6, 16'h06c7, 16'h06c8, 16'h06c9};
   localparam logic [7:0]  CFG_RESET       = 8'h00;

   localparam logic [15:0] VERT_RES_OFS    = 16'h0670;
   localparam logic [15:0] STAT_THR_OFS    = 16'h0672;
   localparam logic [15:0] READ_PTR_OFS    = 16'h0675;
   localparam logic [15:0] EXPORT_VER_OFS  = 16'h0677;
   localparam logic [15:0] PROX_DB_OFS     = 16'h0679;
   localparam logic [15:0] SNAP_DB_OFS     = 16'h067a;
   localparam logic [15:0] SNAP_EN_OFS     = 16'h0699;
   localparam logic [15:0] ONE_EN_OFS      = 16'h06b7;
   localparam logic [15:0] MULTI_EN_OFS    = 16'h06b8;
   localparam logic [15:0] TAP_DIST_OFS    = 16'h06bb;
   localparam logic [15:0] HOLD_TIME_OFS   = 16'h06bd;
   localparam logic [15:0] SW_TIME_OFS     = 16'h06bf;
   localparam logic [15:0] SW_DIST_OFS     = 16'h06c1;
   localparam logic [15:0] SW_REP_OFS      = 16'h06c5;
   localparam logic [15:0] SW_ANGLE_OFS    = 16'h06c7;
   localparam logic [15:0] SCROLL_DIST_OFS = 16'h06c8;
   localparam logic [15:0] FLAGS_ONE_OFS   = 16'h0fe0;
   localparam logic [15:0] FLAGS_MULTI_OFS = 16'h0fe1;

   // Snap enable array geometry
   localparam int unsigned SNAP_ROWS       = 15;
   localparam int unsigned SNAP_COLS       = 10;
   localparam int unsigned SNAP_BYTES      = 30;
   localparam logic [9:0]  SNAP_RESET      = 10'h000;

   // Event bit positions
   localparam int unsigned ONE_BITS        = 6;
   localparam int unsigned MULTI_BITS      = 3;
   localparam int unsigned EV_TAP          = 0;
   localparam int unsigned EV_HOLD         = 1;
   localparam int unsigned EV_XNEG         = 2;
   localparam int unsigned EV_XPOS         = 3;
   localparam int unsigned EV_YPOS         = 4;
   localparam int unsigned EV_YNEG         = 5;
   localparam int unsigned EV_TWO_TAP      = 0;
   localparam int unsigned EV_SCROLL       = 1;
   localparam int unsigned EV_ZOOM         = 2;
   localparam logic [5:0]  ONE_FLAG_RESET  = 6'h00;
   localparam logic [2:0]  MULTI_FLAG_RESET = 3'h0;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } geb_req_s;

   typedef struct packed {
      logic [15:0] vertical_resolution;
      logic [7:0]  stationary_move_threshold;
      logic [15:0] default_read_pointer;
      logic [15:0] export_version;
      logic [7:0]  proximity_debounce;
      logic [7:0]  touch_snap_debounce;
      logic [7:0]  one_touch_gesture_enables;
      logic [7:0]  multi_touch_gesture_enables;
      logic [15:0] tap_distance_limit;
      logic [15:0] hold_time_ms;
      logic [15:0] swipe_start_time_ms;
      logic [15:0] swipe_start_distance;
      logic [15:0] swipe_repeat_distance;
      logic [7:0]  swipe_angle_limit;
      logic [15:0] scroll_start_distance;
   } geb_cfg_s;

endpackage : geb_pkg

// file: src/geb_bank.sv
// Gesture configuration, snap enables and gesture event flags
`timescale 1ns/100ps
module geb_bank (
   input  wire logic                   core_clk_in,
   input  wire logic                   rst_in,
   input  wire geb_pkg::geb_req_s      req_in,
   output logic [7:0]                  rdata_out,
   output logic                        rvalid_out,
   input  wire logic [5:0]             one_touch_evt_in,
   input  wire logic [2:0]             multi_touch_evt_in,
   input  wire logic                   frame_start_in,
   output geb_pkg::geb_cfg_s           cfg_out,
   output logic [149:0]                snap_enable_out,
   output logic [7:0]                  one_touch_flags_out,
   output logic [7:0]                  multi_touch_flags_out
);

   logic [7:0] cfg_q [geb_pkg::CFG_BYTES];
   logic [9:0] snap_q [geb_pkg::SNAP_ROWS];
   logic [5:0] one_flag_q;
   logic [2:0] multi_flag_q;
   logic [5:0] one_set;
   logic [2:0] multi_set;
   logic [7:0] rdata_q;
   logic       rvalid_q;
   logic [7:0] rdata_d;

   // Index of a configuration byte, or -1 when unmapped
   function automatic int cfg_index(input logic [15:0] a);
      int r;
      r = -1;
      for (int i = 0; i < int'(geb_pkg::CFG_BYTES); i++) begin
         if (geb_pkg::CFG_ADDR[i] == a) begin
            r = i;
         end
      end
      return r;
   endfunction : cfg_index

   // Byte offset inside the snap array, or -1 when outside it
   function automatic int snap_index(input logic [15:0] a);
      int r;
      r = -1;
      if (a >= geb_pkg::SNAP_EN_OFS && a < geb_pkg::SNAP_EN_OFS + 16'(geb_pkg::SNAP_BYTES)) begin
         r = int'(a - geb_pkg::SNAP_EN_OFS);
      end
      return r;
   endfunction : snap_index

   function automatic logic [7:0] cfg_byte(input logic [15:0] a);
      logic [7:0] v;
      int         k;
      v = 8'h00;
      k = cfg_index(a);
      if (k >= 0) begin
         v = cfg_q[k];
      end
      return v;
   endfunction : cfg_byte

   // Configuration byte writes
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < int'(geb_pkg::CFG_BYTES); i++) begin
            cfg_q[i] <= geb_pkg::CFG_RESET;
         end
      end else if (req_in.wr && cfg_index(req_in.addr) >= 0) begin
         cfg_q[cfg_index(req_in.addr)] <= req_in.wdata;
      end
   end

   // Snap enable rows, high byte at the even offset
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < int'(geb_pkg::SNAP_ROWS); i++) begin
            snap_q[i] <= geb_pkg::SNAP_RESET;
         end
      end else if (req_in.wr && snap_index(req_in.addr) >= 0) begin
         if (snap_index(req_in.addr) % 2 == 0) begin
            snap_q[snap_index(req_in.addr) / 2][9:8] <= req_in.wdata[1:0]; // [RULE11]
         end else begin
            snap_q[snap_index(req_in.addr) / 2][7:0] <= req_in.wdata; // [RULE10] [RULE11]
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < int'(geb_pkg::SNAP_ROWS); g++) begin : g_snap
         assign snap_enable_out[g*10 +: 10] = snap_q[g]; // [RULE10]
      end
   endgenerate

   // Events latch only when enabled
   always_comb begin
      one_set[geb_pkg::EV_TAP]  = one_touch_evt_in[geb_pkg::EV_TAP]
                                  & cfg_out.one_touch_gesture_enables[geb_pkg::EV_TAP]; // [RULE6]
      one_set[geb_pkg::EV_HOLD] = one_touch_evt_in[geb_pkg::EV_HOLD]
                                  & cfg_out.one_touch_gesture_enables[geb_pkg::EV_HOLD]; // [RULE5]
      one_set[geb_pkg::EV_XNEG] = one_touch_evt_in[geb_pkg::EV_XNEG]
                                  & cfg_out.one_touch_gesture_enables[geb_pkg::EV_XNEG]; // [RULE4]
      one_set[geb_pkg::EV_XPOS] = one_touch_evt_in[geb_pkg::EV_XPOS]
                                  & cfg_out.one_touch_gesture_enables[geb_pkg::EV_XPOS]; // [RULE3]
      one_set[geb_pkg::EV_YPOS] = one_touch_evt_in[geb_pkg::EV_YPOS]
                                  & cfg_out.one_touch_gesture_enables[geb_pkg::EV_YPOS]; // [RULE2]
      one_set[geb_pkg::EV_YNEG] = one_touch_evt_in[geb_pkg::EV_YNEG]
                                  & cfg_out.one_touch_gesture_enables[geb_pkg::EV_YNEG]; // [RULE1]
      multi_set[geb_pkg::EV_TWO_TAP] = multi_touch_evt_in[geb_pkg::EV_TWO_TAP]
                                       & cfg_out.multi_touch_gesture_enables[geb_pkg::EV_TWO_TAP]; // [RULE9]
      multi_set[geb_pkg::EV_SCROLL]  = multi_touch_evt_in[geb_pkg::EV_SCROLL]
                                       & cfg_out.multi_touch_gesture_enables[geb_pkg::EV_SCROLL]; // [RULE8]
      multi_set[geb_pkg::EV_ZOOM]    = multi_touch_evt_in[geb_pkg::EV_ZOOM]
                                       & cfg_out.multi_touch_gesture_enables[geb_pkg::EV_ZOOM]; // [RULE7]
   end

   // Flags live for one report frame; a set in the clearing cycle wins
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         one_flag_q <= geb_pkg::ONE_FLAG_RESET;
      end else if (frame_start_in) begin
         one_flag_q <= one_set; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6]
      end else begin
         one_flag_q <= one_flag_q | one_set;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         multi_flag_q <= geb_pkg::MULTI_FLAG_RESET;
      end else if (frame_start_in) begin
         multi_flag_q <= multi_set; // [RULE7] [RULE8] [RULE9]
      end else begin
         multi_flag_q <= multi_flag_q | multi_set;
      end
   end

   assign one_touch_flags_out   = {2'b00, one_flag_q}; // [RULE12]
   assign multi_touch_flags_out = {5'b00000, multi_flag_q}; // [RULE12]

   // Read mux
   always_comb begin
      int s;
      s = snap_index(req_in.addr);
      rdata_d = 8'h00;
      if (req_in.addr == geb_pkg::FLAGS_ONE_OFS) begin
         rdata_d = {2'b00, one_flag_q}; // [RULE12]
      end else if (req_in.addr == geb_pkg::FLAGS_MULTI_OFS) begin
         rdata_d = {5'b00000, multi_flag_q}; // [RULE12]
      end else if (s >= 0) begin
         if (s % 2 == 0) begin
            rdata_d = {6'b000000, snap_q[s / 2][9:8]}; // [RULE11]
         end else begin
            rdata_d = snap_q[s / 2][7:0]; // [RULE11]
         end
      end else begin
         rdata_d = cfg_byte(req_in.addr);
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req_in.rd;
         if (req_in.rd) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign rdata_out  = rdata_q;
   assign rvalid_out = rvalid_q;

   // Multi-byte fields, high byte at the lower address
   // A process, so that changes of the stored bytes read inside cfg_byte wake it
   always_comb begin
      cfg_out.vertical_resolution         = {cfg_byte(geb_pkg::VERT_RES_OFS),
                                             cfg_byte(geb_pkg::VERT_RES_OFS + 16'h0001)};
      cfg_out.stationary_move_threshold   = cfg_byte(geb_pkg::STAT_THR_OFS);
      cfg_out.default_read_pointer        = {cfg_byte(geb_pkg::READ_PTR_OFS),
                                             cfg_byte(geb_pkg::READ_PTR_OFS + 16'h0001)};
      cfg_out.export_version              = {cfg_byte(geb_pkg::EXPORT_VER_OFS),
                                             cfg_byte(geb_pkg::EXPORT_VER_OFS + 16'h0001)};
      cfg_out.proximity_debounce          = cfg_byte(geb_pkg::PROX_DB_OFS);
      cfg_out.touch_snap_debounce         = cfg_byte(geb_pkg::SNAP_DB_OFS);
      cfg_out.one_touch_gesture_enables   = cfg_byte(geb_pkg::ONE_EN_OFS);
      cfg_out.multi_touch_gesture_enables = cfg_byte(geb_pkg::MULTI_EN_OFS);
      cfg_out.tap_distance_limit          = {cfg_byte(geb_pkg::TAP_DIST_OFS),
                                             cfg_byte(geb_pkg::TAP_DIST_OFS + 16'h0001)};
      cfg_out.hold_time_ms                = {cfg_byte(geb_pkg::HOLD_TIME_OFS),
                                             cfg_byte(geb_pkg::HOLD_TIME_OFS + 16'h0001)};
      cfg_out.swipe_start_time_ms         = {cfg_byte(geb_pkg::SW_TIME_OFS),
                                             cfg_byte(geb_pkg::SW_TIME_OFS + 16'h0001)};
      cfg_out.swipe_start_distance        = {cfg_byte(geb_pkg::SW_DIST_OFS),
                                             cfg_byte(geb_pkg::SW_DIST_OFS + 16'h0001)};
      cfg_out.swipe_repeat_distance       = {cfg_byte(geb_pkg::SW_REP_OFS),
                                             cfg_byte(geb_pkg::SW_REP_OFS + 16'h0001)};
      cfg_out.swipe_angle_limit           = cfg_byte(geb_pkg::SW_ANGLE_OFS);
      cfg_out.scroll_start_distance       = {cfg_byte(geb_pkg::SCROLL_DIST_OFS),
                                             cfg_byte(geb_pkg::SCROLL_DIST_OFS + 16'h0001)};
   end

endmodule : geb_bank

// file: sim/geb_bank_monitor.sv
// Concurrent checks on the gesture event register bank ports
`timescale 1ns/100ps
module geb_bank_monitor (
   input  wire logic              core_clk_in,
   input  wire logic              rst_in,
   input  wire geb_pkg::geb_req_s req_in,
   input  wire logic [7:0]        rdata_out,
   input  wire logic              rvalid_out,
   input  wire logic [5:0]        one_touch_evt_in,
   input  wire logic [2:0]        multi_touch_evt_in,
   input  wire logic              frame_start_in,
   input  wire geb_pkg::geb_cfg_s cfg_out,
   input  wire logic [149:0]      snap_enable_out,
   input  wire logic [7:0]        one_touch_flags_out,
   input  wire logic [7:0]        multi_touch_flags_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   logic [5:0] one_hit;
   logic [2:0] multi_hit;
   assign one_hit   = one_touch_evt_in & cfg_out.one_touch_gesture_enables[5:0];
   assign multi_hit = multi_touch_evt_in & cfg_out.multi_touch_gesture_enables[2:0];
   a_one_accum: assert property (!frame_start_in |=>
      one_touch_flags_out[5:0] == ($past(one_touch_flags_out[5:0]) | $past(one_hit))) else $error("one flags bad");
   a_one_clear: assert property (frame_start_in |=>
      one_touch_flags_out[5:0] == $past(one_hit)) else $error("one flags not cleared");
   a_multi_accum: assert property (!frame_start_in |=>
      multi_touch_flags_out[2:0] == ($past(multi_touch_flags_out[2:0]) | $past(multi_hit))) else $error("multi bad");
   a_multi_clear: assert property (frame_start_in |=>
      multi_touch_flags_out[2:0] == $past(multi_hit)) else $error("multi flags not cleared");
   a_unused_zero: assert property (one_touch_flags_out[7:6] == 2'h0 && multi_touch_flags_out[7:3] == 5'h00)
      else $error("unused flag bits set");
   a_snap_low: assert property (req_in.wr && req_in.addr == 16'h069a |=>
      snap_enable_out[7:0] == $past(req_in.wdata)) else $error("snap low byte");
   a_snap_high: assert property (req_in.wr && req_in.addr == 16'h06b5 |=>
      snap_enable_out[149:148] == $past(req_in.wdata[1:0])) else $error("snap high byte");
   a_flag_read: assert property (req_in.rd && req_in.addr == geb_pkg::FLAGS_ONE_OFS |=>
      rvalid_out && rdata_out == $past(one_touch_flags_out)) else $error("flag read");
   a_read_pulse: assert property (req_in.rd |=> rvalid_out) else $error("no read answer");
   c_one_set: cover property (|one_hit ##1 |one_touch_flags_out);
   c_set_wins: cover property (frame_start_in && |multi_hit);
   c_snap_wr: cover property (req_in.wr && req_in.addr == 16'h06b5);
endmodule : geb_bank_monitor
bind geb_bank geb_bank_monitor u_mon (.core_clk_in, .rst_in, .req_in, .rdata_out, .rvalid_out, .one_touch_evt_in,
   .multi_touch_evt_in, .frame_start_in, .cfg_out, .snap_enable_out, .one_touch_flags_out, .multi_touch_flags_out);

// file: sim/geb_host.sv
// Host register access model for the gesture event register bank
`timescale 1ns/100ps
module geb_host (
   input  wire logic         core_clk_in,
   output geb_pkg::geb_req_s req_out,
   input  wire logic [7:0]   rdata_in,
   input  wire logic         rvalid_in
);
   initial req_out = '0;
   task automatic write(input logic [15:0] addr, input logic [7:0] data);
      @(negedge core_clk_in);
      req_out = '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(negedge core_clk_in);
      req_out = '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
   endtask : write
   task automatic read(input logic [15:0] addr, output logic [7:0] data);
      @(negedge core_clk_in);
      req_out = '{addr: addr, wdata: ~req_out.wdata, wr: 1'b0, rd: 1'b1};
      @(negedge core_clk_in);
      data = rvalid_in ? rdata_in : 8'hxx;
      req_out = '{addr: ~addr, wdata: ~req_out.wdata, wr: 1'b0, rd: 1'b0};
   endtask : read
endmodule : geb_host

// file: sim/testbench.sv
// Self-checking bench for the gesture event register bank
`timescale 1ns/100ps
module testbench;
   logic              core_clk_in;
   logic              rst_in;
   geb_pkg::geb_req_s req;
   logic [7:0]        rdata;
   logic              rvalid;
   logic [5:0]        one_evt;
   logic [2:0]        multi_evt;
   logic              frame_start;
   geb_pkg::geb_cfg_s cfg;
   logic [149:0]      snap;
   logic [7:0]        one_flags;
   logic [7:0]        multi_flags;
   logic [7:0]        rd_val;
   logic [7:0]        one_en;
   logic [7:0]        multi_en;
   int                n_mismatch;
   int                comparisons;
   geb_bank DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
      .one_touch_evt_in(one_evt), .multi_touch_evt_in(multi_evt), .frame_start_in(frame_start), .cfg_out(cfg),
      .snap_enable_out(snap), .one_touch_flags_out(one_flags), .multi_touch_flags_out(multi_flags));
   geb_host u_host (.core_clk_in(core_clk_in), .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic rd_chk(input logic [15:0] addr, input logic [7:0] exp, input string name);
      u_host.read(addr, rd_val);
      chk(name, {8'h00, rd_val}, {8'h00, exp});
   endtask : rd_chk
   task automatic ev(input logic [5:0] one, input logic [2:0] multi, input logic frame);
      @(negedge core_clk_in);
      one_evt = one;
      multi_evt = multi;
      frame_start = frame;
      @(negedge core_clk_in);
      one_evt = 6'h00;
      multi_evt = 3'h0;
      frame_start = 1'b0;
   endtask : ev
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   initial begin
      rst_in = 1'b1;
      one_evt = 6'h00;
      multi_evt = 3'h0;
      frame_start = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      repeat (3) @(posedge core_clk_in);
      @(negedge core_clk_in);
      rst_in = 1'b0;
      for (int i = 0; i < geb_pkg::CFG_BYTES; i++) rd_chk(geb_pkg::CFG_ADDR[i], geb_pkg::CFG_RESET, "cfg reset");
      for (int i = 0; i < geb_pkg::CFG_BYTES; i++) u_host.write(geb_pkg::CFG_ADDR[i], geb_pkg::CFG_ADDR[i][7:0] ^ 8'h5a);
      for (int i = 0; i < geb_pkg::CFG_BYTES; i++) rd_chk(geb_pkg::CFG_ADDR[i], geb_pkg::CFG_ADDR[i][7:0] ^ 8'h5a, "cfg rb");
      chk("tap distance", cfg.tap_distance_limit, {8'hbb ^ 8'h5a, 8'hbc ^ 8'h5a});
      chk("scroll distance", cfg.scroll_start_distance, {8'hc8 ^ 8'h5a, 8'hc9 ^ 8'h5a});
      u_host.write(16'h0673, 8'hff);
      rd_chk(16'h0673, 8'h00, "unmapped");
      u_host.write(geb_pkg::FLAGS_ONE_OFS, 8'hff);
      rd_chk(geb_pkg::FLAGS_ONE_OFS, 8'h00, "flags read only");
      for (int r = 0; r < geb_pkg::SNAP_ROWS; r++) begin
         u_host.write(geb_pkg::SNAP_EN_OFS + 16'(2 * r), 8'hfd);
         u_host.write(geb_pkg::SNAP_EN_OFS + 16'(2 * r + 1), 8'(r * 17));
      end
      for (int r = 0; r < geb_pkg::SNAP_ROWS; r++) begin
         rd_chk(geb_pkg::SNAP_EN_OFS + 16'(2 * r), 8'h01, "snap high");
         rd_chk(geb_pkg::SNAP_EN_OFS + 16'(2 * r + 1), 8'(r * 17), "snap low");
         chk("snap bits", 16'(snap[r * 10 +: 10]), {8'h01, 8'(r * 17)});
      end
      one_en = 8'hed;
      multi_en = 8'he2;
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            one_en = 8'h3f;
            multi_en = 8'h07;
            u_host.write(geb_pkg::ONE_EN_OFS, one_en);
            u_host.write(geb_pkg::MULTI_EN_OFS, multi_en);
         end
         for (int b = 0; b < 6; b++) begin
            ev(6'(1 << b), 3'(1 << b), 1'b0);
            rd_chk(geb_pkg::FLAGS_ONE_OFS, 8'(1 << b) & one_en & 8'h3f, "one flag");
            rd_chk(geb_pkg::FLAGS_MULTI_OFS, 8'(1 << b) & multi_en & 8'h07, "multi flag");
            ev(6'h00, 3'h0, 1'b1);
            rd_chk(geb_pkg::FLAGS_ONE_OFS, 8'h00, "one cleared");
            rd_chk(geb_pkg::FLAGS_MULTI_OFS, 8'h00, "multi cleared");
         end
      end
      ev(6'h3f, 3'h7, 1'b0);
      ev(6'h08, 3'h4, 1'b1);
      rd_chk(geb_pkg::FLAGS_ONE_OFS, 8'h08, "one set wins");
      rd_chk(geb_pkg::FLAGS_MULTI_OFS, 8'h04, "multi set wins");
      chk("one flags port", {8'h00, one_flags}, 16'h0008);
      chk("multi flags port", {8'h00, multi_flags}, 16'h0004);
      close_out();
   end
endmodule : testbench
